// [rtl/adcsr_map.svh]
// constants of the serial register-access block: offsets, field positions,
// reset values and counts; assumes inclusion by adcsr_pkg and the rtl modules.
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define ADCSR_OFS_CMD       6'h00
`define ADCSR_OFS_ADCMODE   6'h01
`define ADCSR_OFS_IFMODE    6'h02
`define ADCSR_OFS_REGCHK    6'h03
`define ADCSR_OFS_DATA      6'h04
`define ADCSR_OFS_GPIO      6'h06
`define ADCSR_OFS_PART      6'h07
`define ADCSR_OFS_CH_FIRST  6'h10
`define ADCSR_OFS_SET_FIRST 6'h20
`define ADCSR_OFS_FLT_FIRST 6'h28
`define ADCSR_OFS_OFF_FIRST 6'h30
`define ADCSR_OFS_GAIN_FIRST 6'h38

// ****************************************
// command byte and interface mode fields
// ****************************************
`define ADCSR_CMD_WEN_BIT   7
`define ADCSR_CMD_DIR_BIT   6
`define ADCSR_IF_WL16_BIT   0
`define ADCSR_IF_STAT_BIT   6

// ****************************************
// reset values
// ****************************************
`define ADCSR_RST_CH0       24'h00_8001
`define ADCSR_RST_CHN       24'h00_0001
`define ADCSR_RST_SETUP     24'h00_1000
`define ADCSR_RST_FILTER    24'h00_0500
`define ADCSR_RST_ADCMODE   24'h00_2000
`define ADCSR_RST_IFMODE    24'h00_0000
`define ADCSR_RST_OFFSET    24'h80_0000
`define ADCSR_RST_ZERO      24'h00_0000

// ****************************************
// counts
// ****************************************
`define ADCSR_CMD_BITS      8
`define ADCSR_RESET_ONES    64

`endif

// [rtl/adcsr_pkg.sv]
// types shared by the serial register-access block; assumes adcsr_map.svh
// sits beside it on the include path.
`include "adcsr_map.svh"

package adcsr_pkg;

    typedef logic [5:0]  adcsr_addr_t;
    typedef logic [23:0] adcsr_word_t;

    typedef enum logic [1:0] {
        ADCSR_ST_CMD,
        ADCSR_ST_WRITE,
        ADCSR_ST_READ
    } adcsr_state_e;

endpackage : adcsr_pkg

// [rtl/adcsr_regs.sv]
// register storage of the converter: setup, channel, filter, calibration and
// mode words; assumes writes arrive already decoded and width-checked.
`timescale 1ns/1ns
`include "adcsr_map.svh"

module adcsr_regs #(
    parameter logic [23:0] GAIN_DEFAULT = 24'h50_0000
) (
    // clock and control
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    input  wire logic              soft_rst,
    // write port
    input  wire logic              wr_en,
    input  wire adcsr_pkg::adcsr_addr_t wr_addr,
    input  wire adcsr_pkg::adcsr_word_t wr_data,
    // read port
    input  wire adcsr_pkg::adcsr_addr_t rd_addr,
    output adcsr_pkg::adcsr_word_t rd_data
);

    import adcsr_pkg::*;

    adcsr_word_t mem_q [64];
    adcsr_word_t mem_d [64];

    // ****************************************
    // power-on contents
    // ****************************************
    function automatic adcsr_word_t reset_word(input adcsr_addr_t a);
        adcsr_word_t w;
        w = `ADCSR_RST_ZERO;
        if (a == `ADCSR_OFS_ADCMODE)                 w = `ADCSR_RST_ADCMODE;
        else if (a == `ADCSR_OFS_IFMODE)             w = `ADCSR_RST_IFMODE;
        else if (a == `ADCSR_OFS_CH_FIRST)           w = `ADCSR_RST_CH0;
        else if (a[5:4] == 2'b01)                    w = `ADCSR_RST_CHN;
        else if (a[5:3] == 3'b100)                   w = `ADCSR_RST_SETUP;
        else if (a[5:3] == 3'b101)                   w = `ADCSR_RST_FILTER;
        else if (a[5:3] == 3'b110)                   w = `ADCSR_RST_OFFSET;
        else if (a[5:3] == 3'b111)                   w = GAIN_DEFAULT;
        return w;
    endfunction : reset_word

    always_comb begin
        for (int i = 0; i < 64; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (clk_en && wr_en) begin
            mem_d[wr_addr] = wr_data;
        end
    end

    // a device reset restores every word, same as power-on
    always_ff @(posedge clk_sys) begin
        if (!resetn || (clk_en && soft_rst)) begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= reset_word(adcsr_addr_t'(i));
            end
        end else begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    assign rd_data = mem_q[rd_addr];

endmodule : adcsr_regs

// [rtl/adcsr_sync.sv]
// two-stage synchroniser for pin inputs; assumes one destination clock and
// that each bit is an independent level.
`timescale 1ns/1ns

module adcsr_sync #(
    parameter int WIDTH   = 3,
    parameter int STAGES  = 2
) (
    // clock and control
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] rst_val,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    if (STAGES != 2 || WIDTH < 1) begin : g_chk
        $error("adcsr_sync supports exactly two stages and a positive width");
    end

    // the first stage feeds only the second
    always_comb begin
        meta_d = meta_q;
        sync_d = sync_out;
        if (clk_en) begin
            meta_d = async_in;
            sync_d = meta_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            meta_q   <= rst_val;
            sync_out <= rst_val;
        end else begin
            meta_q   <= meta_d;
            sync_out <= sync_d;
        end
    end

endmodule : adcsr_sync

// [rtl/adcsr_top.sv]
// serial register-access port of a multiplexed converter; the link pins come
// from another clock domain and are oversampled by clk_sys (>= 8x sclk).
`timescale 1ns/1ns
`include "adcsr_map.svh"

module adcsr_top #(
    parameter logic [15:0] PART_CODE    = 16'h5AC3,    // arbitrary value
    parameter logic [23:0] GAIN_DEFAULT = 24'h50_0000,
    parameter int          RESET_ONES   = `ADCSR_RESET_ONES
) (
    // clock and control
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // serial link pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe_n,
    // conversion side
    input  wire logic [23:0] sample_data,
    input  wire logic [7:0]  sample_status,
    // configuration seen by the converter core
    output logic [15:0]      cfg_adc_mode,
    output logic [15:0]      cfg_if_mode,
    output logic             dev_reset
);

    import adcsr_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (RESET_ONES < 2 || RESET_ONES > 127) begin : g_chk
        $error("adcsr_top: RESET_ONES must lie in 2..127");
    end

    localparam logic [6:0] ONES_LAST = 7'(RESET_ONES);
    localparam logic [5:0] CMD_LAST  = 6'(`ADCSR_CMD_BITS);

    // ****************************************
    // pin synchronisation
    // ****************************************
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       cs_s;
    logic       din_s;

    adcsr_sync #(
        .WIDTH   (3),
        .STAGES  (2)
    ) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .rst_val  (3'b111),
        .async_in ({sclk, cs_n, din}),
        .sync_out (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_s   = pins_s[1];
    assign din_s  = pins_s[0];

    // ****************************************
    // register storage
    // ****************************************
    adcsr_addr_t cmd_addr;
    adcsr_word_t reg_rd;
    adcsr_word_t mode_rd;
    logic        wr_en_q;
    adcsr_addr_t wr_addr_q;
    adcsr_word_t wr_data_q;
    logic        dev_rst_q;

    adcsr_regs #(
        .GAIN_DEFAULT (GAIN_DEFAULT)
    ) u_regs (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .soft_rst (dev_rst_q),
        .wr_en    (wr_en_q),
        .wr_addr  (wr_addr_q),
        .wr_data  (wr_data_q),
        .rd_addr  (cmd_addr),
        .rd_data  (reg_rd)
    );

    // ****************************************
    // register decode
    // ****************************************
    logic [15:0] if_mode;

    // the interface mode word steers the data register length
    assign if_mode  = cfg_if_mode;
    assign mode_rd  = reg_rd;

    function automatic logic [5:0] reg_width(input adcsr_addr_t a, input logic [15:0] ifm);
        logic [5:0] w;
        w = 6'd8;
        if (a == `ADCSR_OFS_ADCMODE || a == `ADCSR_OFS_IFMODE || a == `ADCSR_OFS_GPIO ||
            a == `ADCSR_OFS_PART || a[5:4] == 2'b01 || a[5:4] == 2'b10) begin
            w = 6'd16;
        end else if (a == `ADCSR_OFS_REGCHK || a[5:4] == 2'b11) begin
            w = 6'd24;
        end else if (a == `ADCSR_OFS_DATA) begin
            w = ifm[`ADCSR_IF_WL16_BIT] ? 6'd16 : 6'd24;
            if (ifm[`ADCSR_IF_STAT_BIT]) begin
                w = w + 6'd8;
            end
        end
        return w;
    endfunction : reg_width

    function automatic logic writable(input adcsr_addr_t a);
        return a == `ADCSR_OFS_ADCMODE || a == `ADCSR_OFS_IFMODE ||
               a == `ADCSR_OFS_REGCHK || a == `ADCSR_OFS_GPIO || a[5:4] != 2'b00;
    endfunction : writable

    // value left-justified in 32 bits, first bit out at the top
    function automatic logic [31:0] read_word(input adcsr_addr_t a, input adcsr_word_t r,
                                              input logic [15:0] ifm,
                                              input logic [23:0] smp,
                                              input logic [7:0] st);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == `ADCSR_OFS_PART) begin
            v = {PART_CODE, 16'h0000};
        end else if (a == `ADCSR_OFS_DATA) begin
            v = ifm[`ADCSR_IF_WL16_BIT] ? {smp[23:8], st, 8'h00} : {smp, st};
        end else if (a != `ADCSR_OFS_CMD) begin
            v = {r, 8'h00} << (6'd24 - reg_width(a, ifm));
        end
        return v;
    endfunction : read_word

    // ****************************************
    // serial engine
    // ****************************************
    adcsr_state_e state_q;
    adcsr_state_e state_d;
    logic [5:0]   bit_cnt_q;
    logic [5:0]   bit_cnt_d;
    logic [5:0]   width_q;
    logic [5:0]   width_d;
    adcsr_addr_t  addr_q;
    adcsr_addr_t  addr_d;
    adcsr_word_t  sh_in_q;
    adcsr_word_t  sh_in_d;
    logic [31:0]  sh_out_q;
    logic [31:0]  sh_out_d;
    logic [6:0]   ones_q;
    logic [6:0]   ones_d;
    logic         sclk_prev_q;
    logic         dout_d;
    logic         dout_oe_n_d;
    logic         wr_en_d;
    adcsr_addr_t  wr_addr_d;
    adcsr_word_t  wr_data_d;
    logic         dev_rst_d;
    logic [15:0]  cfg_adc_d;
    logic [15:0]  cfg_if_d;
    logic         rise;
    logic         fall;

    assign rise     = sclk_s & ~sclk_prev_q;
    assign fall     = ~sclk_s & sclk_prev_q;
    assign cmd_addr = state_q == ADCSR_ST_CMD ? {sh_in_q[4:0], din_s} : addr_q;

    always_comb begin
        state_d     = state_q;
        bit_cnt_d   = bit_cnt_q;
        width_d     = width_q;
        addr_d      = addr_q;
        sh_in_d     = sh_in_q;
        sh_out_d    = sh_out_q;
        ones_d      = ones_q;
        dout_d      = dout;
        dout_oe_n_d = cs_s;
        wr_en_d     = 1'b0;
        wr_addr_d   = wr_addr_q;
        wr_data_d   = wr_data_q;
        dev_rst_d   = 1'b0;
        cfg_adc_d   = cfg_adc_mode;
        cfg_if_d    = cfg_if_mode;
        // mirror the mode words so the core sees them from flops
        if (cmd_addr == `ADCSR_OFS_ADCMODE) begin
            cfg_adc_d = mode_rd[15:0];
        end
        if (cmd_addr == `ADCSR_OFS_IFMODE) begin
            cfg_if_d = mode_rd[15:0];
        end
        if (wr_en_q && wr_addr_q == `ADCSR_OFS_ADCMODE) begin
            cfg_adc_d = wr_data_q[15:0];
        end
        if (wr_en_q && wr_addr_q == `ADCSR_OFS_IFMODE) begin
            cfg_if_d = wr_data_q[15:0];
        end
        if (cs_s) begin
            // framing lost: abort and wait for a fresh command
            state_d   = ADCSR_ST_CMD;
            bit_cnt_d = 6'd0;
            dout_d    = 1'b1;
        end else if (rise) begin
            // input is sampled only on rising edges; cs may stay low for good
            sh_in_d = {sh_in_q[22:0], din_s};
            bit_cnt_d = bit_cnt_q + 6'd1;
            if (din_s) begin
                if (ones_q != ONES_LAST) begin
                    ones_d = ones_q + 7'd1;
                end
                if (ones_q + 7'd1 == ONES_LAST) begin
                    dev_rst_d = 1'b1;
                end
            end else begin
                ones_d = 7'd0;
            end
            case (state_q)
                ADCSR_ST_CMD: begin
                    if (bit_cnt_q + 6'd1 == CMD_LAST) begin
                        bit_cnt_d = 6'd0;
                        sh_in_d   = `ADCSR_RST_ZERO;
                        addr_d    = cmd_addr;
                        width_d   = reg_width(cmd_addr, if_mode);
                        // a set enable bit means no valid command: drop it
                        if (sh_in_q[`ADCSR_CMD_WEN_BIT - 1]) begin
                            state_d = ADCSR_ST_CMD;
                        end else if (sh_in_q[`ADCSR_CMD_DIR_BIT - 1]) begin
                            state_d  = ADCSR_ST_READ;
                            sh_out_d = read_word(cmd_addr, reg_rd, if_mode,
                                                 sample_data, sample_status);
                        end else begin
                            state_d = ADCSR_ST_WRITE;
                        end
                    end
                end
                ADCSR_ST_WRITE: begin
                    if (bit_cnt_q + 6'd1 == width_q) begin
                        state_d   = ADCSR_ST_CMD;
                        bit_cnt_d = 6'd0;
                        wr_en_d   = writable(addr_q);
                        wr_addr_d = addr_q;
                        wr_data_d = {sh_in_q[22:0], din_s};
                    end
                end
                ADCSR_ST_READ: begin
                    if (bit_cnt_q + 6'd1 == width_q) begin
                        state_d   = ADCSR_ST_CMD;
                        bit_cnt_d = 6'd0;
                    end
                end
                default: begin
                    state_d   = ADCSR_ST_CMD;
                    bit_cnt_d = 6'd0;
                end
            endcase
        end else if (fall && state_q == ADCSR_ST_READ) begin
            // launch the next bit on the falling edge
            dout_d   = sh_out_q[31];
            sh_out_d = {sh_out_q[30:0], 1'b0};
        end
        if (dev_rst_q) begin
            // whole-device reset: frame state, shift-in and mode mirrors back to power-on; dout and the ones count keep their values
            state_d   = ADCSR_ST_CMD;
            bit_cnt_d = 6'd0;
            sh_in_d   = `ADCSR_RST_ZERO;
            cfg_adc_d = 16'(`ADCSR_RST_ADCMODE);
            cfg_if_d  = 16'(`ADCSR_RST_IFMODE);
            wr_en_d   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q      <= ADCSR_ST_CMD;
            bit_cnt_q    <= 6'd0;
            width_q      <= 6'd8;
            addr_q       <= 6'd0;
            sh_in_q      <= 24'h00_0000;
            sh_out_q     <= 32'h0000_0000;
            ones_q       <= 7'd0;
            sclk_prev_q  <= 1'b1;
            dout         <= 1'b1;
            dout_oe_n    <= 1'b1;
            wr_en_q      <= 1'b0;
            wr_addr_q    <= 6'd0;
            wr_data_q    <= 24'h00_0000;
            dev_rst_q    <= 1'b0;
            cfg_adc_mode <= 16'(`ADCSR_RST_ADCMODE);
            cfg_if_mode  <= 16'(`ADCSR_RST_IFMODE);
        end else if (clk_en) begin
            state_q      <= state_d;
            bit_cnt_q    <= bit_cnt_d;
            width_q      <= width_d;
            addr_q       <= addr_d;
            sh_in_q      <= sh_in_d;
            sh_out_q     <= sh_out_d;
            ones_q       <= ones_d;
            sclk_prev_q  <= sclk_s;
            dout         <= dout_d;
            dout_oe_n    <= dout_oe_n_d;
            wr_en_q      <= wr_en_d;
            wr_addr_q    <= wr_addr_d;
            wr_data_q    <= wr_data_d;
            dev_rst_q    <= dev_rst_d;
            cfg_adc_mode <= cfg_adc_d;
            cfg_if_mode  <= cfg_if_d;
        end
    end

    assign dev_reset = dev_rst_q;

endmodule : adcsr_top

// [sim/adcsr_asserts.sv]
// checker of the serial block's pins and mirrors, bound to adcsr_top
// assumes sclk halves of at least four clk_sys; checks pause while clk_en is low
`timescale 1ns/1ns
module adcsr_asserts #(
    parameter int RESET_ONES = 64
) (
    // clock and control
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        clk_en,
    // link pins
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        din,
    input wire logic        dout,
    input wire logic        dout_oe_n,
    // converter side
    input wire logic [23:0] sample_data,
    input wire logic [7:0]  sample_status,
    input wire logic [15:0] cfg_adc_mode,
    input wire logic [15:0] cfg_if_mode,
    input wire logic        dev_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !clk_en);
    // ****
    // properties
    // ****
    a_reset_state: assert property ($rose(resetn) |-> dout && dout_oe_n && !dev_reset
        && cfg_adc_mode == 16'h2000 && cfg_if_mode == 16'h0000) else $error("bad reset state");
    a_idle_high: assert property (cs_n[*5] |-> dout_oe_n && dout)
        else $error("dout not released");
    a_drive_low: assert property (!cs_n[*5] |-> !dout_oe_n)
        else $error("dout not driven");
    a_dout_hold: assert property ((sclk && !cs_n)[*6] |-> $stable(dout))
        else $error("dout moved while sclk high");
    a_pulse_once: assert property (dev_reset |=> !dev_reset)
        else $error("reset pulse too long");
    a_pulse_cause: assert property (dev_reset |-> $past(din, 3) && $past(din, 6))
        else $error("reset pulse without ones");
    a_mode_reload: assert property (dev_reset |=> cfg_adc_mode == 16'h2000
        && cfg_if_mode == 16'h0000) else $error("mirrors not restored");
    a_abort_quiet: assert property ($changed(cfg_adc_mode)
        |-> $past(dev_reset) || !$past(cs_n, 8)) else $error("write outside a frame");
    c_reset: cover property (dev_reset);
    c_read: cover property (!dout_oe_n ##1 !dout);
    c_write: cover property ($changed(cfg_adc_mode));
endmodule : adcsr_asserts

bind adcsr_top adcsr_asserts #(.RESET_ONES(RESET_ONES)) adcsr_asserts_inst (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .sample_data(sample_data),
    .sample_status(sample_status), .cfg_adc_mode(cfg_adc_mode),
    .cfg_if_mode(cfg_if_mode), .dev_reset(dev_reset));

// [sim/adcsr_host.sv]
// host model: serial master of the link, mode three, msb first
// assumes clk_sys is the bench clock; sclk halves are four clk_sys (200 ns)
`timescale 1ns/1ns
module adcsr_host (
    // bench clock
    input  wire logic clk_sys,
    // framing choice: keep cs_n low between frames
    input  wire logic three_wire,
    // link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b1;
    end
    // one frame; command bit7 low, bit6 picks direction
    task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
        rx = '0;
        @(posedge clk_sys) cs_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_sys);
            sclk <= 1'b0;
            din <= tx[i];
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys) rx[i] = dout;
            @(posedge clk_sys) sclk <= 1'b1;
            repeat (3) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        if (!three_wire) cs_n <= 1'b1;
        din <= ~din; // released line must not look like the last bit
        repeat (4) @(posedge clk_sys);
    endtask : xfer
endmodule : adcsr_host

// [sim/adcsr_top_tb_top.sv]
// bench of adcsr_top: host model on the link, one task per scenario
// assumes adcsr_host.sv and adcsr_asserts.sv are compiled before it
`timescale 1ns/1ns
module adcsr_top_tb_top;
    // ****
    // design, host and clock
    // ****
    localparam logic [15:0] PART_CODE = 16'h1E96; // arbitrary value
    localparam logic [23:0] SAMPLE    = 24'hC3_5A96;
    localparam logic [7:0]  STATUS    = 8'h3C;
    localparam logic [5:0]  TA [10]   = '{6'h07, 6'h10, 6'h11, 6'h20, 6'h28, 6'h30, 6'h01,
                                          6'h02, 6'h04, 6'h05};
    localparam int          TW [10]   = '{16, 16, 16, 16, 16, 24, 16, 16, 24, 8};
    localparam logic [31:0] TE [10]   = '{32'(PART_CODE), 32'h8001, 32'h0001, 32'h1000,
        32'h0500, 32'h80_0000, 32'h2000, 32'h0000, 32'(SAMPLE), 32'h0000};
    logic        clk_sys = 1'b0;
    logic        resetn  = 1'b0;
    logic        clk_en  = 1'b1;
    logic        three_wire = 1'b0;
    logic        sclk, cs_n, din, dout, dout_oe_n, dev_reset;
    logic [15:0] cfg_adc_mode, cfg_if_mode;
    logic [39:0] rx;
    logic [31:0] v;
    int          bad_count, check_count, pulses, cyc;

    adcsr_host adcsr_host_inst (.clk_sys(clk_sys), .three_wire(three_wire), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout(dout));
    // short ones count keeps the device reset quick
    adcsr_top #(.PART_CODE(PART_CODE), .RESET_ONES(8)) adcsr_top_inst (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .sample_data(SAMPLE),
        .sample_status(STATUS), .cfg_adc_mode(cfg_adc_mode), .cfg_if_mode(cfg_if_mode),
        .dev_reset(dev_reset));

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (dev_reset === 1'b1) pulses++;
        if (cyc > 90000) begin
            bad_count++;
            conclude();
        end
    end
    // ****
    // shared tasks
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [5:0] a, input int w);
        adcsr_host_inst.xfer(40'({2'b01, a}) << w, 8 + w, rx);
        v = 32'(rx & ((40'h1 << w) - 40'h1));
    endtask : rd
    task automatic test_reset();
        @(negedge clk_sys);
        check("dout", 32'(dout), 32'h1);
        check("dout enable", 32'(dout_oe_n), 32'h1);
        check("adc mode pins", 32'(cfg_adc_mode), 32'h2000);
        check("if mode pins", 32'(cfg_if_mode), 32'h0000);
        $display("reset state done");
    endtask : test_reset
    task automatic test_defaults();
        three_wire = 1'b1;
        foreach (TA[i]) begin
            rd(TA[i], TW[i]);
            check("register", v, TE[i]);
        end
        three_wire = 1'b0;
        $display("default reads done");
    endtask : test_defaults
    task automatic test_write();
        adcsr_host_inst.xfer(40'h01_1234, 24, rx);
        check("adc mode pins", 32'(cfg_adc_mode), 32'h1234);
        rd(6'h01, 16);
        check("adc mode read", v, 32'h1234);
        $display("write done");
    endtask : test_write
    // a frame sent while the clock enable is low must leave no trace
    task automatic test_freeze();
        @(posedge clk_sys) clk_en <= 1'b0;
        adcsr_host_inst.xfer(40'h01_5555, 24, rx);
        @(posedge clk_sys) clk_en <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("frozen adc mode pins", 32'(cfg_adc_mode), 32'h1234);
        rd(6'h01, 16);
        check("frozen adc mode read", v, 32'h1234);
        $display("clock enable freeze done");
    endtask : test_freeze
    task automatic test_status();
        adcsr_host_inst.xfer(40'h02_0041, 24, rx);
        check("if mode pins", 32'(cfg_if_mode), 32'h0041);
        rd(6'h04, 24);
        check("data and status", v, 32'({SAMPLE[23:8], STATUS}));
        $display("status append done");
    endtask : test_status
    task automatic test_abort();
        adcsr_host_inst.xfer(40'h02A5, 16, rx);
        rd(6'h02, 16);
        check("if mode read", v, 32'h0000);
        check("if mode pins", 32'(cfg_if_mode), 32'h0000);
        $display("abort done");
    endtask : test_abort
    task automatic test_ones();
        pulses = 0;
        adcsr_host_inst.xfer(40'hFFFF, 16, rx);
        check("reset pulses", 32'(pulses), 32'h1);
        check("adc mode pins", 32'(cfg_adc_mode), 32'h2000);
        check("if mode pins", 32'(cfg_if_mode), 32'h0000);
        rd(6'h01, 16);
        check("adc mode read", v, 32'h2000);
        $display("ones reset done");
    endtask : test_ones
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_defaults();
        test_write();
        test_freeze();
        test_abort();
        test_status();
        test_ones();
        conclude();
    end
endmodule : adcsr_top_tb_top
